// ===== core/acf_config_low.sv
// configuration word receiver with low-field decode and pin pullup control
`timescale 1ns/10ps
`default_nettype none
module acf_config_low
   import acf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic [15:0] cfg_readback,
   output acf_low_fields_t low_fields,
   output logic serial_out_data_ready_pullup,
   output logic cfg_written
);
   // pin synchronisers: stage one is read by stage two only
   logic cs_meta_r;
   logic cs_sync_r;
   logic sclk_meta_r;
   logic sclk_sync_r;
   logic sclk_prev_r;
   logic sdi_meta_r;
   logic sdi_sync_r;

   // word assembly
   logic sclk_rise;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic word_last;

   // configuration state
   logic word_commit;
   logic [15:0] cfg_r;
   logic [15:0] cfg_nxt;
   logic written_nxt;

   // true when the received word carries the write pattern
   function automatic logic qual_is_valid(input logic [15:0] word);
      logic [1:0] qual;
      qual = word[BIT_QUAL_HI:BIT_QUAL_LO];
      return (qual == QUAL_VALID);
   endfunction

   // bit counter step; wraps so back-to-back words need no deselect
   function automatic logic [4:0] cnt_step(input logic [4:0] cnt);
      logic [4:0] step;
      if (cnt == BIT_CNT_LAST) begin
         step = BIT_CNT_ZERO;
      end else begin
         step = cnt + 5'h01;
      end
      return step;
   endfunction

   // host view of a stored word: the reserved bit never reads low
   function automatic logic [15:0] with_reserved(input logic [15:0] word);
      logic [15:0] view;
      view = word;
      view[BIT_RSVD] = 1'b1;
      return view;
   endfunction

   // field view of a stored word, in carrier order
   function automatic acf_low_fields_t low_view(input logic [15:0] word);
      acf_low_fields_t view;
      view.temp_sensor_select = word[BIT_TEMP_SEL];
      view.output_pullup_enable = word[BIT_PULLUP];
      view.write_qualifier = word[BIT_QUAL_HI:BIT_QUAL_LO];
      return view;
   endfunction

   // weak pullup only while deselected; when selected the pin belongs to its driver
   function automatic logic pullup_on(input logic [15:0] word, input logic deselected);
      return word[BIT_PULLUP] & deselected;
   endfunction

   // chip select stage one; reset parks it deselected
   always_ff @(posedge clock) begin
      if (rst) begin
         cs_meta_r <= 1'b1;
      end else begin
         cs_meta_r <= cs_n;
      end
   end

   // chip select stage two
   always_ff @(posedge clock) begin
      if (rst) begin
         cs_sync_r <= 1'b1;
      end else begin
         cs_sync_r <= cs_meta_r;
      end
   end

   // serial clock stage one; idle level is low, so no false edge after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_meta_r <= 1'b0;
      end else begin
         sclk_meta_r <= sclk;
      end
   end

   // serial clock stage two
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_sync_r <= 1'b0;
      end else begin
         sclk_sync_r <= sclk_meta_r;
      end
   end

   // delayed copy of stage two for edge detection
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_prev_r <= 1'b0;
      end else begin
         sclk_prev_r <= sclk_sync_r;
      end
   end

   // serial data stage one; same latency as the clock path keeps them aligned
   always_ff @(posedge clock) begin
      if (rst) begin
         sdi_meta_r <= 1'b0;
      end else begin
         sdi_meta_r <= sdi;
      end
   end

   // serial data stage two
   always_ff @(posedge clock) begin
      if (rst) begin
         sdi_sync_r <= 1'b0;
      end else begin
         sdi_sync_r <= sdi_meta_r;
      end
   end

   // rise: stage two high while its delayed copy is still low
   assign sclk_rise = sclk_sync_r & ~sclk_prev_r;

   // chip select high abandons any partial word
   always_comb begin
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      if (cs_sync_r) begin
         shift_nxt = 16'h0000;
         cnt_nxt = BIT_CNT_ZERO;
      end else if (sclk_rise) begin
         shift_nxt = {shift_r[14:0], sdi_sync_r};
         cnt_nxt = cnt_step(cnt_r);
      end
   end

   // shift register, msb arrives first
   always_ff @(posedge clock) begin
      if (rst) begin
         shift_r <= 16'h0000;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   // bits received in the current word
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_r <= BIT_CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // sixteenth bit of a selected word; earlier bits never commit
   assign word_last = !cs_sync_r && sclk_rise
                      && (cnt_r == BIT_CNT_LAST);
   // all-0 and all-1 words fail the qualifier, so a static data line is harmless
   assign word_commit = word_last && qual_is_valid(shift_nxt);

   always_comb begin
      cfg_nxt = cfg_r;
      written_nxt = 1'b0;
      if (word_commit) begin
         cfg_nxt = shift_nxt;
         written_nxt = 1'b1;
      end
   end

   // stored configuration word
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_r <= CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // one-cycle commit pulse, aligned with the new word
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_written <= 1'b0;
      end else begin
         cfg_written <= written_nxt;
      end
   end

   // bit 0 is stored as written but never shown
   assign cfg_readback = with_reserved(cfg_r);

   // fields follow the stored word, not the word in flight
   assign low_fields = low_view(cfg_r);

   // follows chip select two cycles late, through its synchroniser
   assign serial_out_data_ready_pullup = pullup_on(cfg_r, cs_sync_r);
endmodule
`default_nettype wire

// ===== core/acf_pkg.sv
// package for the converter configuration low-field decoder
// Notes on behaviour
// - temp select: 0 converts inputs, 1 temperature
// - pullup enable weakly pulls pin while deselected
// - only qualifier 01 updates configuration register
// - static serial input never writes configuration
// - bit 0 ignores writes, reads as 1 (stored as written here; only the readback forces it to 1)
// - configuration reachable only through serial interface
package acf_pkg;
   localparam int unsigned CFG_W = 16;
   localparam int unsigned BIT_TEMP_SEL = 4;
   localparam int unsigned BIT_PULLUP = 3;
   localparam int unsigned BIT_QUAL_HI = 2;
   localparam int unsigned BIT_QUAL_LO = 1;
   localparam int unsigned BIT_RSVD = 0;
   localparam logic [15:0] CFG_RESET = 16'h058b;
   localparam logic [1:0] QUAL_VALID = 2'h1;
   localparam logic [4:0] BIT_CNT_LAST = 5'h0f;
   localparam logic [4:0] BIT_CNT_ZERO = 5'h00;

   typedef struct packed {
      logic temp_sensor_select;
      logic output_pullup_enable;
      logic [1:0] write_qualifier;
   } acf_low_fields_t;
endpackage

// ===== bench/acf_chk.sv
// concurrent checks on the configuration decoder's ports
`timescale 1ns/10ps
`default_nettype none
module acf_chk
   import acf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic [15:0] cfg_readback,
   input wire acf_low_fields_t low_fields,
   input wire logic serial_out_data_ready_pullup,
   input wire logic cfg_written
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   rsvd_bit_a: assert property (cfg_readback[0]) else $error("reserved bit read low");
   qual_gate_a: assert property (cfg_written |-> cfg_readback[2:1] == 2'h1) else $error("bad qualifier stored");
   cfg_hold_a: assert property (!cfg_written |-> $stable(cfg_readback)) else $error("stray change");
   fields_map_a: assert property (low_fields == acf_low_fields_t'(cfg_readback[4:1])) else $error("field map");
   pullup_follow_a: assert property (serial_out_data_ready_pullup == (cfg_readback[3] && $past(cs_n, 2)))
      else $error("pullup state");
   commit_select_a: assert property (cfg_written |-> !$past(cs_n, 3)) else $error("commit deselected");
   pulse_once_a: assert property (cfg_written |=> !cfg_written) else $error("long commit pulse");
   cover property (cfg_written);
   cover property (cfg_readback[4]);
   cover property (!cfg_readback[3]);
endmodule
`default_nettype wire

// ===== bench/acf_host.sv
// serial host model
`timescale 1ns/10ps
`default_nettype none
module acf_host (
   input wire logic clock,
   output var logic cs_n = 1'h1,
   output var logic sclk = 1'h0,
   output var logic sdi = 1'h0
);
   // sends the top nbits of w, msb first; fewer than 16 models a cut frame
   task automatic send(input logic [15:0] w, input int nbits);
      @(posedge clock);
      for (int i = 31; i >= 32 - 2 * nbits; i--) begin
         {cs_n, sclk, sdi} <= {1'h0, !i[0], w[i/2]};
         repeat (4) @(posedge clock);
      end
      // released data line toggles so a stale bit is never trusted
      {cs_n, sclk, sdi} <= {1'h1, 1'h0, !sdi};
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ===== bench/adc_config_low_fields_tb.sv
// decoder bench
`timescale 1ns/10ps
`default_nettype none
module adc_config_low_fields_tb import acf_pkg::*;;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic serial_out_data_ready_pullup;
   logic cfg_written;
   logic [15:0] cfg_readback;
   acf_low_fields_t low_fields;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int writes = 0;
   initial forever #5 clock = ~clock;
   acf_host u_acf_host (
      .clock(clock),
      .cs_n(cs_n),
      .sclk(sclk),
      .sdi(sdi)
   );
   acf_config_low u_acf_config_low (
      .clock(clock),
      .rst(rst),
      .cs_n(cs_n),
      .sclk(sclk),
      .sdi(sdi),
      .cfg_readback(cfg_readback),
      .low_fields(low_fields),
      .serial_out_data_ready_pullup(serial_out_data_ready_pullup),
      .cfg_written(cfg_written)
   );
   task automatic chk(input logic [15:0] seen, input logic [15:0] expected);
      comparisons++;
      if (seen !== expected) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, expected);
      end
   endtask
   task automatic conclude();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // six frames and two resets need about 800 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         conclude();
      end
   end
   // counted on the falling edge, clear of the design's update
   always @(negedge clock) begin
      if (cfg_written === 1'b1) begin
         writes++;
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'h0;
      u_acf_host.send(16'hffff, 16);
      @(negedge clock);
      chk(cfg_readback, 16'h058b);
      chk(low_fields, 16'h0005);
      chk(serial_out_data_ready_pullup, 16'h0001);
      u_acf_host.send(16'h0000, 16);
      @(negedge clock);
      chk(cfg_readback, 16'h058b);
      u_acf_host.send(16'h0014, 16);
      @(negedge clock);
      chk(cfg_readback, 16'h058b);
      u_acf_host.send(16'h000a, 12);
      @(negedge clock);
      chk(cfg_readback, 16'h058b);
      u_acf_host.send(16'h0012, 16);
      @(negedge clock);
      chk(cfg_readback, 16'h0013);
      chk(low_fields, 16'h0009);
      chk(serial_out_data_ready_pullup, 16'h0000);
      u_acf_host.send(16'h000a, 16);
      @(negedge clock);
      chk(cfg_readback, 16'h000b);
      chk(low_fields, 16'h0005);
      chk(serial_out_data_ready_pullup, 16'h0001);
      chk(writes, 16'h0002);
      // mid-run reset must bring back the power-on word
      @(posedge clock);
      rst <= 1'h1;
      repeat (6) @(posedge clock);
      rst <= 1'h0;
      @(negedge clock);
      chk(cfg_readback, 16'h058b);
      chk(low_fields, 16'h0005);
      chk(serial_out_data_ready_pullup, 16'h0001);
      conclude();
   end
endmodule
bind acf_config_low acf_chk u_acf_chk (
   .clock(clock),
   .rst(rst),
   .cs_n(cs_n),
   .cfg_readback(cfg_readback),
   .low_fields(low_fields),
   .serial_out_data_ready_pullup(serial_out_data_ready_pullup),
   .cfg_written(cfg_written)
);
`default_nettype wire
